// ---- rtl/cacp_pkg.sv ----
// Shared constants and types for the counter array capture/compare/PWM slice.
package cacp_pkg;

    localparam int NUM_BLOCKS = 2;
    localparam int MODS_PER_BLOCK = 3;
    localparam int NUM_MODS = 6;
    localparam int PRESCALE_W = 15;

    // Special function register addresses, indexed by block or by module, except the single shared status register.
    localparam logic [1:0][7:0] ADDR_CNT_LOW = {8'hBA, 8'hA2};
    localparam logic [1:0][7:0] ADDR_CNT_HIGH = {8'hBB, 8'hA3};
    localparam logic [1:0][7:0] ADDR_CONTROL = {8'hBC, 8'hA4};
    localparam logic [1:0][7:0] ADDR_PERIOD = {8'hC7, 8'hB4};
    localparam logic [1:0][7:0] ADDR_PRESCALE = {8'hFC, 8'hFB};
    localparam logic [7:0] ADDR_STATUS = 8'hA5;
    localparam logic [5:0][7:0] ADDR_MODE = {8'hBF, 8'hBE, 8'hBD, 8'hAB, 8'hAA, 8'hA9};
    localparam logic [5:0][7:0] ADDR_CMP_LOW = {8'hC5, 8'hC3, 8'hC1, 8'hB2, 8'hAF, 8'hAC};
    localparam logic [5:0][7:0] ADDR_CMP_HIGH = {8'hC6, 8'hC4, 8'hC2, 8'hB3, 8'hB1, 8'hAD};

    // Prescaler register fields.
    localparam int PS_CE_BIT = 4;
    localparam int PS_EXP_LSB = 0;
    localparam int PS_EXP_W = 4;
    localparam logic [7:0] PS_RESET = 8'h10;
    localparam logic [7:0] PS_MASK = 8'h1F;

    // Block control register fields.
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_SEL_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h43;
    localparam logic [1:0] CLK_PRESCALE = 2'h0;
    localparam logic [1:0] CLK_TIMER0 = 2'h1;
    localparam logic [1:0] CLK_EXTERNAL = 2'h2;

    // Module mode register fields.
    localparam int MODE_INT_EN = 7;
    localparam int MODE_COMP_EN = 6;
    localparam int MODE_CAP_RISE = 5;
    localparam int MODE_CAP_FALL = 4;
    localparam int MODE_MATCH = 3;
    localparam int MODE_TOGGLE = 2;
    localparam int MODE_PWM_LSB = 0;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] PWM_OFF = 2'h0;
    localparam logic [1:0] PWM_FIXED = 2'h1;
    localparam logic [1:0] PWM_PROG = 2'h2;

    localparam logic [7:0] LOW_BYTE_MAX = 8'hFF;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] cmpLow;
        logic [7:0] cmpHigh;
        logic capPrev;
        logic pinOut;
    } cacp_mod_type;

    typedef struct packed {
        logic [7:0] prescale;
        logic [7:0] control;
        logic [15:0] count;
        logic [7:0] period;
        logic [7:0] periodAct;
        logic extPrev;
    } cacp_blk_type;

    typedef struct packed {
        cacp_mod_type [5:0] mods;
        cacp_blk_type [1:0] blks;
        logic [5:0] status;
        logic [5:0] irq;
        logic [7:0] rdData;
    } cacp_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wr;
        logic rd;
    } cacp_sfr_type;

endpackage

// ---- rtl/cacp_prescaler.sv ----
// Power-of-two clock prescaler producing a one-cycle tick.
`timescale 1ns/1ps
module cacp_prescaler #(
    parameter int CNT_W = cacp_pkg::PRESCALE_W
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [3:0] exponent,
    output logic tick
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } cacp_ps_state_type;

    cacp_ps_state_type s_ff;
    cacp_ps_state_type nxt_s;

    // All ones in the low bits selected by the exponent.
    function automatic logic [CNT_W-1:0] low_mask(input logic [3:0] e);
        logic [CNT_W:0] one;
        one = (CNT_W+1)'(1);
        return CNT_W'((one << e) - one);
    endfunction

    assign tick = enable & (&(s_ff.cnt | ~low_mask(exponent)));

    always_comb
    begin
        nxt_s = s_ff;
        if (enable)
        begin
            nxt_s.cnt = s_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

endmodule

// ---- rtl/cacp_top.sv ----
// Two counter blocks with three capture/compare/PWM modules each, behind an SFR port.
`timescale 1ns/1ps
// How it works
// - Prescaler bit 4 gates clock, reset on.
// - Prescaled rate is oscillator over two^exponent.
// - Block one has own enable and exponent.
// - Modules 0-2 block 0, 3-5 block 1.
// - Each module: capture, timer, toggle or PWM.
// - Capture copies counter into compare pair.
// - Capture edge: rising, falling or both.
// - Capture raises request only when enabled.
// - Timer compares pair with counter, flags match.
// - Toggle mode inverts pin on match.
// - Fixed PWM period is low-byte overflow unless a block module is prog PWM.
// - PWM high when low byte reaches compare.
// - Fixed PWM overflow reloads low from high.
// - Fixed PWM chosen per module, own pin; period mode set per block.
// - Period match clears counter, reloads values.
// - One period register shared per block.
// - Programmable PWM duty from module high byte.
// - Counter source: prescaler, timer0 or pin.
module cacp_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire cacp_pkg::cacp_sfr_type sfrReq,
    output logic [7:0] sfrRdData,
    input wire logic [5:0] captureIn,
    input wire logic timer0Overflow,
    input wire logic [1:0] extClkIn,
    output logic [5:0] moduleOut,
    output logic [5:0] irqReq
);

    cacp_pkg::cacp_state_type s_ff;
    cacp_pkg::cacp_state_type nxt_s;
    logic [1:0] prescaleTick;

    // Block index of a module.
    function automatic int blk_of(input int m);
        return m / cacp_pkg::MODS_PER_BLOCK;
    endfunction

    // True when the mode selects either 8-bit PWM flavour.
    function automatic logic is_pwm(input logic [7:0] mode);
        return mode[cacp_pkg::MODE_PWM_LSB +: 2] != cacp_pkg::PWM_OFF;
    endfunction

    genvar gb;
    generate
        for (gb = 0; gb < cacp_pkg::NUM_BLOCKS; gb++)
        begin : g_ps
            cacp_prescaler #(
                .CNT_W(cacp_pkg::PRESCALE_W)
            ) u_ps (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .enable(s_ff.blks[gb].prescale[cacp_pkg::PS_CE_BIT]),
                .exponent(s_ff.blks[gb].prescale[cacp_pkg::PS_EXP_LSB +: cacp_pkg::PS_EXP_W]),
                .tick(prescaleTick[gb])
            );
        end
    endgenerate

    assign sfrRdData = s_ff.rdData;
    assign moduleOut = {s_ff.mods[5].pinOut, s_ff.mods[4].pinOut, s_ff.mods[3].pinOut,
                        s_ff.mods[2].pinOut, s_ff.mods[1].pinOut, s_ff.mods[0].pinOut};
    assign irqReq = s_ff.irq;

    always_comb
    begin
        logic [1:0] advance;
        logic [1:0] progMode;
        logic [1:0] pulseStart;
        logic [1:0] srcTick;
        logic [1:0][15:0] cntNext;
        logic [5:0] eventSet;
        logic [5:0] statusClr;
        logic [7:0] rd;
        logic [7:0] md;
        logic [15:0] cmpVal;
        logic edgeRise;
        logic edgeFall;
        logic matchHit;
        int b;
        advance = '0;
        progMode = '0;
        pulseStart = '0;
        srcTick = '0;
        cntNext = '0;
        eventSet = '0;
        statusClr = '0;
        rd = 8'h00;
        md = 8'h00;
        cmpVal = 16'h0000;
        edgeRise = 1'b0;
        edgeFall = 1'b0;
        matchHit = 1'b0;
        b = 0;
        nxt_s = s_ff;

        // Counter clocking and period handling per block.
        for (int i = 0; i < cacp_pkg::NUM_BLOCKS; i++)
        begin
            nxt_s.blks[i].extPrev = extClkIn[i];
            unique case (s_ff.blks[i].control[cacp_pkg::CTRL_SEL_LSB +: 2])
                cacp_pkg::CLK_PRESCALE: srcTick[i] = prescaleTick[i];
                cacp_pkg::CLK_TIMER0: srcTick[i] = timer0Overflow;
                cacp_pkg::CLK_EXTERNAL: srcTick[i] = extClkIn[i] & ~s_ff.blks[i].extPrev;
                default: srcTick[i] = 1'b0;
            endcase
            advance[i] = s_ff.blks[i].control[cacp_pkg::CTRL_RUN_BIT] & srcTick[i];
            for (int m = 0; m < cacp_pkg::NUM_MODS; m++)
            begin
                if (blk_of(m) == i &&
                    s_ff.mods[m].mode[cacp_pkg::MODE_PWM_LSB +: 2] == cacp_pkg::PWM_PROG)
                begin
                    progMode[i] = 1'b1;
                end
            end
            cntNext[i] = s_ff.blks[i].count + 16'h0001;
            if (progMode[i])
            begin
                if (advance[i] && s_ff.blks[i].count[7:0] == s_ff.blks[i].periodAct)
                begin
                    pulseStart[i] = 1'b1;
                    cntNext[i] = 16'h0000;
                    nxt_s.blks[i].periodAct = s_ff.blks[i].period;
                end
            end
            else
            begin
                pulseStart[i] = advance[i] &&
                    s_ff.blks[i].count[7:0] == cacp_pkg::LOW_BYTE_MAX;
                nxt_s.blks[i].periodAct = s_ff.blks[i].period;
            end
            if (advance[i])
            begin
                nxt_s.blks[i].count = cntNext[i];
            end
        end

        // Module behaviour.
        for (int m = 0; m < cacp_pkg::NUM_MODS; m++)
        begin
            b = blk_of(m);
            md = s_ff.mods[m].mode;
            cmpVal = {s_ff.mods[m].cmpHigh, s_ff.mods[m].cmpLow};
            nxt_s.mods[m].capPrev = captureIn[m];
            edgeRise = captureIn[m] & ~s_ff.mods[m].capPrev;
            edgeFall = ~captureIn[m] & s_ff.mods[m].capPrev;
            matchHit = advance[b] && md[cacp_pkg::MODE_COMP_EN] && cntNext[b] == cmpVal;
            if (is_pwm(md))
            begin
                if (pulseStart[b])
                begin
                    nxt_s.mods[m].cmpLow = s_ff.mods[m].cmpHigh;
                    nxt_s.mods[m].pinOut = 1'b0;
                end
                else
                begin
                    // Compare the count shown after this edge, so the pin rises with the counter.
                    nxt_s.mods[m].pinOut = (advance[b] ? cntNext[b][7:0] :
                        s_ff.blks[b].count[7:0]) >= s_ff.mods[m].cmpLow;
                end
            end
            else if ((edgeRise && md[cacp_pkg::MODE_CAP_RISE]) ||
                     (edgeFall && md[cacp_pkg::MODE_CAP_FALL]))
            begin
                nxt_s.mods[m].cmpLow = s_ff.blks[b].count[7:0];
                nxt_s.mods[m].cmpHigh = s_ff.blks[b].count[15:8];
                eventSet[m] = 1'b1;
            end
            else if (matchHit && md[cacp_pkg::MODE_TOGGLE])
            begin
                nxt_s.mods[m].pinOut = ~s_ff.mods[m].pinOut;
                eventSet[m] = 1'b1;
            end
            else if (matchHit && md[cacp_pkg::MODE_MATCH])
            begin
                eventSet[m] = 1'b1;
            end
        end

        // Register writes; a write wins over the loads above, except a compare write in a cycle where its module sets an event.
        if (sfrReq.wr)
        begin
            if (sfrReq.addr == cacp_pkg::ADDR_STATUS)
            begin
                statusClr = sfrReq.wrData[5:0];
            end
            for (int i = 0; i < cacp_pkg::NUM_BLOCKS; i++)
            begin
                if (sfrReq.addr == cacp_pkg::ADDR_PRESCALE[i])
                begin
                    nxt_s.blks[i].prescale = sfrReq.wrData & cacp_pkg::PS_MASK;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CONTROL[i])
                begin
                    nxt_s.blks[i].control = sfrReq.wrData & cacp_pkg::CTRL_MASK;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_PERIOD[i])
                begin
                    nxt_s.blks[i].period = sfrReq.wrData;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CNT_LOW[i])
                begin
                    nxt_s.blks[i].count[7:0] = sfrReq.wrData;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CNT_HIGH[i])
                begin
                    nxt_s.blks[i].count[15:8] = sfrReq.wrData;
                end
            end
            for (int m = 0; m < cacp_pkg::NUM_MODS; m++)
            begin
                if (sfrReq.addr == cacp_pkg::ADDR_MODE[m])
                begin
                    nxt_s.mods[m].mode = sfrReq.wrData;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CMP_LOW[m] && !eventSet[m])
                begin
                    nxt_s.mods[m].cmpLow = sfrReq.wrData;
                    nxt_s.mods[m].mode[cacp_pkg::MODE_COMP_EN] = 1'b0;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CMP_HIGH[m] && !eventSet[m])
                begin
                    nxt_s.mods[m].cmpHigh = sfrReq.wrData;
                    nxt_s.mods[m].mode[cacp_pkg::MODE_COMP_EN] = 1'b1;
                end
            end
        end

        // Status flags: a new event wins over a clear in the same cycle.
        nxt_s.status = (s_ff.status & ~statusClr) | eventSet;
        for (int m = 0; m < cacp_pkg::NUM_MODS; m++)
        begin
            nxt_s.irq[m] = nxt_s.status[m] & nxt_s.mods[m].mode[cacp_pkg::MODE_INT_EN];
        end

        // Read data, registered one cycle after the read strobe.
        if (sfrReq.rd)
        begin
            if (sfrReq.addr == cacp_pkg::ADDR_STATUS)
            begin
                rd = {2'h0, s_ff.status};
            end
            for (int i = 0; i < cacp_pkg::NUM_BLOCKS; i++)
            begin
                if (sfrReq.addr == cacp_pkg::ADDR_PRESCALE[i])
                begin
                    rd = s_ff.blks[i].prescale;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CONTROL[i])
                begin
                    rd = s_ff.blks[i].control;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_PERIOD[i])
                begin
                    rd = s_ff.blks[i].period;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CNT_LOW[i])
                begin
                    rd = s_ff.blks[i].count[7:0];
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CNT_HIGH[i])
                begin
                    rd = s_ff.blks[i].count[15:8];
                end
            end
            for (int m = 0; m < cacp_pkg::NUM_MODS; m++)
            begin
                if (sfrReq.addr == cacp_pkg::ADDR_MODE[m])
                begin
                    rd = s_ff.mods[m].mode;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CMP_LOW[m])
                begin
                    rd = s_ff.mods[m].cmpLow;
                end
                if (sfrReq.addr == cacp_pkg::ADDR_CMP_HIGH[m])
                begin
                    rd = s_ff.mods[m].cmpHigh;
                end
            end
            nxt_s.rdData = rd;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            s_ff <= '0;
            for (int i = 0; i < cacp_pkg::NUM_BLOCKS; i++)
            begin
                s_ff.blks[i].prescale <= cacp_pkg::PS_RESET;
                s_ff.blks[i].control <= cacp_pkg::CTRL_RESET;
            end
            for (int m = 0; m < cacp_pkg::NUM_MODS; m++)
            begin
                s_ff.mods[m].mode <= cacp_pkg::MODE_RESET;
            end
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

endmodule

// ---- tb/cacp_pin_model.sv ----
// Port pin model: capture inputs, timer 0 overflow and external clocks.
`timescale 1ns/1ps
module cacp_pin_model (
    input wire logic core_clk,
    output logic [5:0] captureIn,
    output logic timer0Overflow,
    output logic [1:0] extClkIn
);
    initial
    begin
        captureIn = 6'h00;
        timer0Overflow = 1'b0;
        extClkIn = 2'h0;
    end
    task automatic set_cap(input int idx, input logic v);
        @(negedge core_clk);
        captureIn[idx] = v;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic pulse_t0(input int n);
        repeat (n)
        begin
            @(negedge core_clk);
            timer0Overflow = 1'b1;
            @(negedge core_clk);
            timer0Overflow = 1'b0;
        end
    endtask
    // Each level is held two cycles so the pin runs at no more than a quarter of the core rate.
    task automatic ext_edges(input int b, input int n);
        repeat (n)
        begin
            @(negedge core_clk);
            extClkIn[b] = 1'b1;
            repeat (2) @(negedge core_clk);
            extClkIn[b] = 1'b0;
            @(negedge core_clk);
        end
    endtask
endmodule

// ---- tb/cacp_props.sv ----
// Port checker for the counter array slice.
`timescale 1ns/1ps
module cacp_props (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire cacp_pkg::cacp_sfr_type sfrReq,
    input wire logic [7:0] sfrRdData,
    input wire logic [5:0] captureIn,
    input wire logic timer0Overflow,
    input wire logic [1:0] extClkIn,
    input wire logic [5:0] moduleOut,
    input wire logic [5:0] irqReq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // Shadow of the mode registers, rebuilt from the writes seen on the port.
    logic [5:0][7:0] modeSh_ff;
    logic [5:0][7:0] nxt_modeSh;
    logic [5:0] intEn;
    always_comb
    begin
        nxt_modeSh = modeSh_ff;
        for (int i = 0; i < 6; i++)
        begin
            if (sfrReq.wr && sfrReq.addr == cacp_pkg::ADDR_MODE[i])
            begin
                nxt_modeSh[i] = sfrReq.wrData;
            end
            intEn[i] = modeSh_ff[i][cacp_pkg::MODE_INT_EN];
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            modeSh_ff <= '0;
        else
            modeSh_ff <= nxt_modeSh;
    end
    reset_outs_a: assert property (disable iff (1'b0) !rst_b |=>
        sfrRdData == 8'h00 && moduleOut == 6'h00 && irqReq == 6'h00) else $error("reset outputs");
    rd_hold_a: assert property (!sfrReq.rd |=> $stable(sfrRdData)) else $error("read data moved");
    unmapped_rd_a: assert property (sfrReq.rd && sfrReq.addr == 8'h80 |=> sfrRdData == 8'h00)
        else $error("unmapped read");
    ps_pad_a: assert property (sfrReq.rd && sfrReq.addr inside {8'hFB, 8'hFC} |=>
        sfrRdData[7:5] == 3'h0) else $error("prescale pad bits");
    st_pad_a: assert property (sfrReq.rd && sfrReq.addr == 8'hA5 |=>
        sfrRdData[7:6] == 2'h0) else $error("status pad bits");
    ctl_pad_a: assert property (sfrReq.rd && sfrReq.addr inside {8'hA4, 8'hBC} |=>
        (sfrRdData & ~cacp_pkg::CTRL_MASK) == 8'h00) else $error("control pad bits");
    irq_fall_a: assert property ($past(rst_b) && |($past(irqReq) & ~irqReq) |->
        $past(sfrReq.wr)) else $error("request dropped without write");
    irq_enable_a: assert property ((irqReq & ~intEn & ~$past(intEn)) == 6'h00)
        else $error("request without enable");
    for (genvar g = 0; g < 6; g++)
    begin : g_cap
        sequence capRise;
            $past(rst_b) && captureIn[g] && !$past(captureIn[g]);
        endsequence
        sequence capArm;
            intEn[g] && modeSh_ff[g][cacp_pkg::MODE_CAP_RISE] && modeSh_ff[g][1:0] == 2'h0;
        endsequence
        cap_irq_a: assert property (capRise ##0 capArm |-> ##[1:2] irqReq[g])
            else $error("capture gave no request");
    end
endmodule
bind cacp_top cacp_props u_props (.core_clk(core_clk), .rst_b(rst_b), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .captureIn(captureIn), .timer0Overflow(timer0Overflow),
    .extClkIn(extClkIn), .moduleOut(moduleOut), .irqReq(irqReq));

// ---- tb/tb_top.sv ----
// Self-checking bench for the counter array slice.
`timescale 1ns/1ps
module tb_top;
    typedef struct {string nm; logic [7:0] exp; logic [7:0] msk;} cacp_note_type;
    logic core_clk;
    logic rst_b;
    cacp_pkg::cacp_sfr_type sfrReq;
    logic [7:0] sfrRdData;
    logic [5:0] captureIn;
    logic timer0Overflow;
    logic [1:0] extClkIn;
    logic [5:0] moduleOut;
    logic [5:0] irqReq;
    int bad_count = 0;
    int n_checks = 0;
    logic [7:0] seed = 8'h63;
    cacp_note_type notes[$];
    cacp_note_type nt;
    logic rdSeen_ff = 1'b0;
    logic [7:0] v1, v2;
    int cnt[6];
    cacp_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
        .captureIn(captureIn), .timer0Overflow(timer0Overflow), .extClkIn(extClkIn),
        .moduleOut(moduleOut), .irqReq(irqReq));
    cacp_pin_model u_pins (.core_clk(core_clk), .captureIn(captureIn),
        .timer0Overflow(timer0Overflow), .extClkIn(extClkIn));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [7:0] lfsr();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfrReq.addr = a;
        sfrReq.wrData = d;
        sfrReq.wr = 1'b1;
        @(negedge core_clk);
        sfrReq.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, string nm);
        @(negedge core_clk);
        notes.push_back('{nm, e, m});
        sfrReq.addr = a;
        sfrReq.rd = 1'b1;
        @(negedge core_clk);
        sfrReq.rd = 1'b0;
    endtask
    task automatic count_hi();
        cnt = '{default: 0};
        repeat (256)
        begin
            @(negedge core_clk);
            for (int i = 0; i < 6; i++)
                cnt[i] += int'(moduleOut[i] === 1'b1);
        end
    endtask
    // Read results are compared in the cycle after the strobe, oldest note first.
    always @(posedge core_clk) rdSeen_ff <= sfrReq.rd && rst_b;
    always @(negedge core_clk)
    begin
        if (rdSeen_ff && notes.size() == 0)
            chk("note queue", 16'h0001, 16'h0000);
        else if (rdSeen_ff)
        begin
            nt = notes.pop_front();
            chk(nt.nm, nt.exp & nt.msk, sfrRdData & nt.msk);
        end
    end
    initial
    begin
        repeat (10000) @(negedge core_clk);
        chk("timeout", 16'h0000, 16'h0001);
        tally_and_finish();
    end
    initial
    begin
        sfrReq = '0;
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        rd(cacp_pkg::ADDR_PRESCALE[0], 8'h10, 8'hFF, "ps0 reset");
        rd(cacp_pkg::ADDR_PRESCALE[1], 8'h10, 8'hFF, "ps1 reset");
        rd(cacp_pkg::ADDR_CONTROL[1], 8'h00, 8'hFF, "ctl reset");
        rd(cacp_pkg::ADDR_STATUS, 8'h00, 8'hFF, "status reset");
        rd(8'h80, 8'h00, 8'hFF, "unmapped");
        for (int i = 0; i < 6; i++)
        begin
            rd(cacp_pkg::ADDR_MODE[i], 8'h00, 8'hFF, "mode reset");
            v1 = lfsr();
            wr(cacp_pkg::ADDR_CMP_LOW[i], v1);
            rd(cacp_pkg::ADDR_CMP_LOW[i], v1, 8'hFF, "cmp low");
            v1 = lfsr();
            wr(cacp_pkg::ADDR_CMP_HIGH[i], v1);
            rd(cacp_pkg::ADDR_CMP_HIGH[i], v1, 8'hFF, "cmp high");
        end
        for (int b = 0; b < 2; b++)
        begin
            v1 = lfsr();
            wr(cacp_pkg::ADDR_PRESCALE[b], v1);
            rd(cacp_pkg::ADDR_PRESCALE[b], v1 & 8'h1F, 8'hFF, "prescale");
            wr(cacp_pkg::ADDR_PERIOD[b], v1);
            rd(cacp_pkg::ADDR_PERIOD[b], v1, 8'hFF, "period");
        end
        wr(cacp_pkg::ADDR_PRESCALE[1], 8'h10);
        wr(cacp_pkg::ADDR_PRESCALE[0], 8'h00);
        wr(cacp_pkg::ADDR_CONTROL[0], 8'h40);
        rd(cacp_pkg::ADDR_CNT_LOW[0], 8'h00, 8'h00, "peek");
        v1 = sfrRdData;
        repeat (20) @(negedge core_clk);
        rd(cacp_pkg::ADDR_CNT_LOW[0], v1, 8'hFF, "gated count");
        wr(cacp_pkg::ADDR_PRESCALE[0], 8'h13);
        wr(cacp_pkg::ADDR_CNT_LOW[0], 8'h00);
        repeat (80) @(negedge core_clk);
        rd(cacp_pkg::ADDR_CNT_LOW[0], 8'h00, 8'h00, "peek");
        chk("divide by 8", 16'h0001, 16'(sfrRdData inside {8'h0A, 8'h0B}));
        wr(cacp_pkg::ADDR_PRESCALE[0], 8'h10);
        wr(cacp_pkg::ADDR_CONTROL[0], 8'h41);
        wr(cacp_pkg::ADDR_CNT_LOW[0], 8'h00);
        wr(cacp_pkg::ADDR_CONTROL[1], 8'h42);
        wr(cacp_pkg::ADDR_CNT_LOW[1], 8'h00);
        u_pins.pulse_t0(5);
        u_pins.ext_edges(1, 3);
        u_pins.ext_edges(0, 2);
        rd(cacp_pkg::ADDR_CNT_LOW[0], 8'h05, 8'hFF, "timer0 count");
        rd(cacp_pkg::ADDR_CNT_LOW[1], 8'h03, 8'hFF, "ext count");
        wr(cacp_pkg::ADDR_CONTROL[0], 8'h00);
        wr(cacp_pkg::ADDR_CONTROL[1], 8'h00);
        // Capture table: rise with request, fall without, both with request.
        for (int k = 0; k < 3; k++)
        begin
            automatic logic [7:0] cm = (k == 0) ? 8'hA0 : (k == 1) ? 8'h10 : 8'hB0;
            automatic int m = (k == 0) ? 0 : (k == 1) ? 4 : 2;
            v1 = lfsr();
            v2 = lfsr();
            wr(cacp_pkg::ADDR_STATUS, 8'h3F);
            wr(cacp_pkg::ADDR_MODE[m], cm);
            wr(cacp_pkg::ADDR_CNT_LOW[m / 3], v1);
            wr(cacp_pkg::ADDR_CNT_HIGH[m / 3], v2);
            u_pins.set_cap(m, 1'b1);
            wr(cacp_pkg::ADDR_CNT_LOW[m / 3], v2);
            u_pins.set_cap(m, 1'b0);
            rd(cacp_pkg::ADDR_CMP_LOW[m], (k == 0) ? v1 : v2, 8'hFF, "capt low");
            rd(cacp_pkg::ADDR_CMP_HIGH[m], v2, 8'hFF, "capt high");
            rd(cacp_pkg::ADDR_STATUS, 8'h01 << m, 8'h3F, "capt flag");
            chk("capt irq", 16'(cm[7]), 16'(irqReq[m]));
            wr(cacp_pkg::ADDR_MODE[m], 8'h00);
        end
        wr(cacp_pkg::ADDR_STATUS, 8'h3F);
        wr(cacp_pkg::ADDR_CNT_LOW[0], 8'h00);
        wr(cacp_pkg::ADDR_CNT_HIGH[0], 8'h00);
        wr(cacp_pkg::ADDR_MODE[1], 8'h04);
        wr(cacp_pkg::ADDR_CMP_LOW[1], 8'h10);
        wr(cacp_pkg::ADDR_CMP_HIGH[1], 8'h00);
        wr(cacp_pkg::ADDR_MODE[2], 8'h88);
        wr(cacp_pkg::ADDR_CMP_LOW[2], 8'h20);
        wr(cacp_pkg::ADDR_CMP_HIGH[2], 8'h00);
        wr(cacp_pkg::ADDR_CONTROL[0], 8'h40);
        repeat (60) @(negedge core_clk);
        chk("toggle pin", 16'h0001, 16'(moduleOut[1]));
        chk("timer pin", 16'h0000, 16'(moduleOut[2]));
        chk("irq", 16'h0004, 16'(irqReq));
        rd(cacp_pkg::ADDR_STATUS, 8'h06, 8'h3F, "match flags");
        wr(cacp_pkg::ADDR_STATUS, 8'h3F);
        wr(cacp_pkg::ADDR_MODE[1], 8'h00);
        wr(cacp_pkg::ADDR_MODE[0], 8'h01);
        wr(cacp_pkg::ADDR_MODE[2], 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            wr(cacp_pkg::ADDR_CMP_HIGH[0], (k == 0) ? 8'h80 : 8'h00);
            wr(cacp_pkg::ADDR_CMP_HIGH[2], (k == 0) ? 8'hC0 : 8'hFF);
            repeat (300) @(negedge core_clk);
            count_hi();
            chk("pwm0 high", (k == 0) ? 16'h0080 : 16'h00FF, 16'(cnt[0]));
            chk("pwm2 high", (k == 0) ? 16'h0040 : 16'h0001, 16'(cnt[2]));
        end
        rd(cacp_pkg::ADDR_CMP_LOW[0], 8'h00, 8'hFF, "pwm reload");
        wr(cacp_pkg::ADDR_CONTROL[0], 8'h00);
        // All three modules of block 1 share the mode, with the period above every duty.
        wr(cacp_pkg::ADDR_PERIOD[1], 8'h3F);
        wr(cacp_pkg::ADDR_CNT_LOW[1], 8'h00);
        for (int m = 3; m < 6; m++)
        begin
            wr(cacp_pkg::ADDR_MODE[m], 8'h02);
            wr(cacp_pkg::ADDR_CMP_HIGH[m], (m == 3) ? 8'h10 : (m == 4) ? 8'h20 : 8'h3E);
        end
        wr(cacp_pkg::ADDR_CONTROL[1], 8'h40);
        repeat (300) @(negedge core_clk);
        count_hi();
        chk("prog3 high", 16'h00C0, 16'(cnt[3]));
        chk("prog4 high", 16'h0080, 16'(cnt[4]));
        chk("prog5 high", 16'h0008, 16'(cnt[5]));
        rd(cacp_pkg::ADDR_CNT_LOW[1], 8'h00, 8'hC0, "prog wrap");
        tally_and_finish();
    end
endmodule
